// ---- ucgf_pkg.sv ----
// Shared constants, types and decode functions for the serial clock and framing block.
package ucgf_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADR_DATA = 8'h00;
    localparam logic [7:0] ADR_CSA = 8'h04;
    localparam logic [7:0] ADR_CSC = 8'h08;
    localparam logic [7:0] ADR_DIVL = 8'h0C;
    localparam logic [7:0] ADR_DIVH = 8'h10;

    localparam int CSA_DBL_SPEED = 0;
    localparam int CSA_FRAME_ERR = 1;
    localparam int CSA_OVERRUN = 2;
    localparam int CSA_NINTH = 3;
    localparam int CSA_RX_READY = 4;
    localparam int CSA_TX_EMPTY = 5;

    localparam int CSC_SYNC = 0;
    localparam int CSC_POL = 1;
    localparam int CSC_XDIR = 2;
    localparam int CSC_PAR_LO = 3;
    localparam int CSC_STOP2 = 5;
    localparam int CSC_SIZE_LO = 6;
    localparam int CSC_TX_NINTH = 9;

    localparam int QW_NINTH = 8;
    localparam int QW_FRAME_ERR = 9;
    localparam int QW_OVERRUN = 10;

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [11:0] DIV_RST = 12'h000;
    localparam logic [9:0] CSC_RST = 10'h0C0;
    localparam logic [3:0] OVS_NORMAL_LAST = 4'hF;
    localparam logic [3:0] OVS_DOUBLE_LAST = 4'h7;
    localparam logic [3:0] OVS_NORMAL_MID = 4'h7;
    localparam logic [3:0] OVS_DOUBLE_MID = 4'h3;
    localparam logic [1:0] QUEUE_DEPTH = 2'h2;

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} ucgf_state_t;

    // ************************************************************
    // Frame decode
    // ************************************************************
    function automatic logic [3:0] ucgf_nbits(input logic [2:0] sz);
        case (sz)
            3'h0: return 4'h5;
            3'h1: return 4'h6;
            3'h2: return 4'h7;
            3'h7: return 4'h9;
            default: return 4'h8;
        endcase
    endfunction : ucgf_nbits

    function automatic logic ucgf_parity(input logic [8:0] d, input logic [2:0] sz,
                                         input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < ucgf_nbits(sz)) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction : ucgf_parity

endpackage : ucgf_pkg

// ---- ucgf_baud_gen.sv ----
// Baud rate down-counter producing one tick per divisor plus one system clocks.
`timescale 1ns/1ps
module ucgf_baud_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] div_i,
    input wire logic reload_i,
    output logic tick_o
);

    logic [11:0] cnt_reg;
    logic [11:0] cnt_next;

    // ************************************************************
    // Counter
    // ************************************************************
    always_comb begin
        if (reload_i || cnt_reg == 12'h000) begin
            cnt_next = div_i;
        end else begin
            cnt_next = cnt_reg - 12'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= ucgf_pkg::DIV_RST;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick_o = (cnt_reg == 12'h000);

    a_baud_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick_o || reload_i) |=> (cnt_reg == $past(div_i)))
        else $error("baud counter did not reload the divisor");

endmodule : ucgf_baud_gen

// ---- ucgf_top.sv ----
// Serial block: register slave, clock generation, transmitter and two-level receive queue.
//
// Summary of operation
// - Two receive buffers form a circular queue; each character read once.
// - Frame error, overrun and ninth bit travel in the queue with data.
// - With both buffers full, a finished character waits until next start bit.
// - Four clock modes; one bit picks asynchronous or synchronous.
// - In synchronous mode pin direction picks master drive or slave sampling.
// - Transfer clock pin unused in both asynchronous modes.
// - Down-counter reloads divisor at zero or low write; ticks at zero.
// - Transmit bit clock is baud tick divided by 16, 8 or 2.
// - Receiver steps 16, 8 or 2 states per bit on the baud tick.
// - Divisor is twelve bits across high and low registers, 0 to 4095.
// - Double speed receiver uses 8 samples per bit, not 16.
// - Slave clock passes synchroniser and edge detector, two clocks late.
// - Receive samples on the edge opposite the transmit change edge.
// - Polarity zero: change on falling, sample on rising; one swaps.
// - Frames: one start, 5 to 9 data, optional parity, 1 or 2 stops.
// - Order: start, data least significant first, parity, stops.
// - After last stop, next frame follows at once or line idles high.
// - Even parity is xor of data bits; odd parity is its inverse.
// - Receiver checks only the first stop bit for frame error.
// - Start bit is low and every stop bit high.
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module ucgf_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic xck_i,
    output logic xck_o,
    output logic xck_oe_n_o
);

    // ************************************************************
    // Register slave
    // ************************************************************
    logic ack_reg, ack_next, dbl_reg, dbl_next, reload_reg, reload_next;
    logic [31:0] dat_reg, dat_next;
    logic [9:0] csc_reg, csc_next;
    logic [11:0] div_reg, div_next;
    logic req, wr, rd_data, wr_data, pop;
    logic [10:0] head;
    logic tx_full_reg, tx_full_next;
    logic [1:0] q_cnt_reg, q_cnt_next;

    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd_data = req && !wb_we_i && wb_adr_i == ucgf_pkg::ADR_DATA;
    assign wr_data = wr && wb_adr_i == ucgf_pkg::ADR_DATA;
    assign pop = rd_data && q_cnt_reg != 2'h0;

    always_comb begin
        ack_next = req;
        dat_next = dat_reg;
        dbl_next = dbl_reg;
        csc_next = csc_reg;
        div_next = div_reg;
        reload_next = 1'b0;
        if (req && !wb_we_i) begin
            dat_next = 32'h0000_0000;
            case (wb_adr_i)
                ucgf_pkg::ADR_DATA: dat_next[8:0] = (q_cnt_reg != 2'h0) ? head[8:0] : 9'h000;
                ucgf_pkg::ADR_CSA: begin
                    dat_next[ucgf_pkg::CSA_DBL_SPEED] = dbl_reg;
                    dat_next[ucgf_pkg::CSA_FRAME_ERR] = head[ucgf_pkg::QW_FRAME_ERR];
                    dat_next[ucgf_pkg::CSA_OVERRUN] = head[ucgf_pkg::QW_OVERRUN];
                    dat_next[ucgf_pkg::CSA_NINTH] = head[ucgf_pkg::QW_NINTH];
                    dat_next[ucgf_pkg::CSA_RX_READY] = q_cnt_reg != 2'h0;
                    dat_next[ucgf_pkg::CSA_TX_EMPTY] = !tx_full_reg;
                end
                ucgf_pkg::ADR_CSC: dat_next[9:0] = csc_reg;
                ucgf_pkg::ADR_DIVL: dat_next[7:0] = div_reg[7:0];
                ucgf_pkg::ADR_DIVH: dat_next[3:0] = div_reg[11:8];
                default: dat_next = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                ucgf_pkg::ADR_CSA: dbl_next = wb_dat_i[ucgf_pkg::CSA_DBL_SPEED];
                ucgf_pkg::ADR_CSC: begin
                    csc_next[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) begin
                        csc_next[9:8] = wb_dat_i[9:8];
                    end
                end
                ucgf_pkg::ADR_DIVL: begin
                    div_next[7:0] = wb_dat_i[7:0];
                    reload_next = 1'b1;
                end
                ucgf_pkg::ADR_DIVH: div_next[11:8] = wb_dat_i[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            dbl_reg <= 1'b0;
            csc_reg <= ucgf_pkg::CSC_RST;
            div_reg <= ucgf_pkg::DIV_RST;
            reload_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            dbl_reg <= dbl_next;
            csc_reg <= csc_next;
            div_reg <= div_next;
            reload_reg <= reload_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ************************************************************
    // Clock generation
    // ************************************************************
    logic tick, sync_mode, master, slave, pol, stop2, par_en, par_odd;
    logic [2:0] size;
    logic [3:0] nb, last, mid;
    logic xint_reg, xint_next, s1_reg, s2_reg, s3_reg;
    logic rise, fall, change_edge, sample_edge;

    // Reload waits a cycle so the counter loads the freshly written low byte.
    ucgf_baud_gen u_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .div_i(div_reg),
        .reload_i(reload_reg),
        .tick_o(tick)
    );

    assign sync_mode = csc_reg[ucgf_pkg::CSC_SYNC];
    assign master = sync_mode && csc_reg[ucgf_pkg::CSC_XDIR];
    assign slave = sync_mode && !csc_reg[ucgf_pkg::CSC_XDIR];
    assign pol = csc_reg[ucgf_pkg::CSC_POL];
    assign stop2 = csc_reg[ucgf_pkg::CSC_STOP2];
    assign par_en = csc_reg[ucgf_pkg::CSC_PAR_LO + 1];
    assign par_odd = csc_reg[ucgf_pkg::CSC_PAR_LO];
    assign size = csc_reg[ucgf_pkg::CSC_SIZE_LO +: 3];
    assign nb = ucgf_pkg::ucgf_nbits(size);
    assign last = dbl_reg ? ucgf_pkg::OVS_DOUBLE_LAST : ucgf_pkg::OVS_NORMAL_LAST;
    assign mid = dbl_reg ? ucgf_pkg::OVS_DOUBLE_MID : ucgf_pkg::OVS_NORMAL_MID;

    assign xint_next = master ? (xint_reg ^ tick) : 1'b0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xint_reg <= 1'b0;
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            xint_reg <= xint_next;
            s1_reg <= xck_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // The slave clock is only edge-detected after the synchroniser pair.
    assign rise = master ? (tick && !xint_reg) : (slave && s2_reg && !s3_reg);
    assign fall = master ? (tick && xint_reg) : (slave && !s2_reg && s3_reg);
    assign change_edge = pol ? rise : fall;
    assign sample_edge = pol ? fall : rise;
    assign xck_o = xint_reg;
    assign xck_oe_n_o = !master;

    // ************************************************************
    // Transmitter
    // ************************************************************
    ucgf_pkg::ucgf_state_t tx_st_reg, tx_st_next;
    logic [8:0] txbuf_reg, txbuf_next, tsh_reg, tsh_next;
    logic [3:0] tbit_reg, tbit_next, tdiv_reg, tdiv_next;
    logic txd_reg, txd_next, tpar_reg, tpar_next, tx_bit, load;

    assign tx_bit = sync_mode ? change_edge : (tick && tdiv_reg == last);

    always_comb begin
        tx_st_next = tx_st_reg;
        txbuf_next = txbuf_reg;
        tx_full_next = tx_full_reg;
        tsh_next = tsh_reg;
        tbit_next = tbit_reg;
        txd_next = txd_reg;
        tpar_next = tpar_reg;
        tdiv_next = sync_mode ? 4'h0 : (tick ? ((tdiv_reg == last) ? 4'h0 : tdiv_reg + 4'h1)
                                             : tdiv_reg);
        load = 1'b0;
        if (tx_bit) begin
            case (tx_st_reg)
                ucgf_pkg::ST_IDLE: load = tx_full_reg;
                ucgf_pkg::ST_START: begin
                    txd_next = tsh_reg[0];
                    tsh_next = {1'b0, tsh_reg[8:1]};
                    tbit_next = 4'h1;
                    tx_st_next = ucgf_pkg::ST_DATA;
                end
                ucgf_pkg::ST_DATA: begin
                    if (tbit_reg == nb) begin
                        txd_next = par_en ? tpar_reg : 1'b1;
                        tbit_next = 4'h0;
                        tx_st_next = par_en ? ucgf_pkg::ST_PARITY : ucgf_pkg::ST_STOP;
                    end else begin
                        txd_next = tsh_reg[0];
                        tsh_next = {1'b0, tsh_reg[8:1]};
                        tbit_next = tbit_reg + 4'h1;
                    end
                end
                ucgf_pkg::ST_PARITY: begin
                    txd_next = 1'b1;
                    tx_st_next = ucgf_pkg::ST_STOP;
                end
                ucgf_pkg::ST_STOP: begin
                    if (stop2 && tbit_reg == 4'h0) begin
                        tbit_next = 4'h1;
                    end else begin
                        load = tx_full_reg;
                        tx_st_next = ucgf_pkg::ST_IDLE;
                    end
                end
                default: tx_st_next = ucgf_pkg::ST_IDLE;
            endcase
        end
        if (load) begin
            tsh_next = txbuf_reg;
            tpar_next = ucgf_pkg::ucgf_parity(txbuf_reg, size, par_odd);
            tx_full_next = 1'b0;
            txd_next = 1'b0;
            tx_st_next = ucgf_pkg::ST_START;
        end
        if (wr_data && !tx_full_reg) begin
            txbuf_next = {csc_reg[ucgf_pkg::CSC_TX_NINTH], wb_dat_i[7:0]};
            tx_full_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st_reg <= ucgf_pkg::ST_IDLE;
            txbuf_reg <= 9'h000;
            tx_full_reg <= 1'b0;
            tsh_reg <= 9'h000;
            tbit_reg <= 4'h0;
            tdiv_reg <= 4'h0;
            txd_reg <= 1'b1;
            tpar_reg <= 1'b0;
        end else begin
            tx_st_reg <= tx_st_next;
            txbuf_reg <= txbuf_next;
            tx_full_reg <= tx_full_next;
            tsh_reg <= tsh_next;
            tbit_reg <= tbit_next;
            tdiv_reg <= tdiv_next;
            txd_reg <= txd_next;
            tpar_reg <= tpar_next;
        end
    end

    assign txd_o = txd_reg;

    // ************************************************************
    // Receiver and queue
    // ************************************************************
    ucgf_pkg::ucgf_state_t rx_st_reg, rx_st_next;
    logic [3:0] rcnt_reg, rcnt_next, rbit_reg, rbit_next;
    logic [8:0] rsh_reg, rsh_next;
    logic [10:0] held_w_reg, held_w_next, word;
    logic [10:0] mem_reg [2];
    logic [10:0] mem_next [2];
    logic held_reg, held_next, ovp_reg, ovp_next, wp_reg, wp_next, rp_reg, rp_next;
    logic samp, start_det, done, push;
    logic [1:0] room;

    assign samp = sync_mode ? sample_edge
                  : (tick && rcnt_reg == ((rx_st_reg == ucgf_pkg::ST_START) ? mid : last));
    assign start_det = rx_st_reg == ucgf_pkg::ST_IDLE && !rxd_i && (sync_mode ? sample_edge : tick);
    assign done = samp && rx_st_reg == ucgf_pkg::ST_STOP;
    assign word = {ovp_reg, !rxd_i, rsh_reg >> (4'h9 - nb)};
    assign room = q_cnt_reg - {1'b0, pop};
    assign head = mem_reg[rp_reg];

    always_comb begin
        rx_st_next = rx_st_reg;
        rsh_next = rsh_reg;
        rbit_next = rbit_reg;
        rcnt_next = (!sync_mode && tick && rx_st_reg != ucgf_pkg::ST_IDLE)
                    ? (samp ? 4'h0 : rcnt_reg + 4'h1) : rcnt_reg;
        case (rx_st_reg)
            ucgf_pkg::ST_IDLE: begin
                rcnt_next = 4'h0;
                rbit_next = 4'h0;
                if (start_det) begin
                    rx_st_next = sync_mode ? ucgf_pkg::ST_DATA : ucgf_pkg::ST_START;
                end
            end
            ucgf_pkg::ST_START: begin
                if (samp) begin
                    rx_st_next = rxd_i ? ucgf_pkg::ST_IDLE : ucgf_pkg::ST_DATA;
                end
            end
            ucgf_pkg::ST_DATA: begin
                if (samp) begin
                    rsh_next = {rxd_i, rsh_reg[8:1]};
                    rbit_next = rbit_reg + 4'h1;
                    if (rbit_reg + 4'h1 == nb) begin
                        rx_st_next = par_en ? ucgf_pkg::ST_PARITY : ucgf_pkg::ST_STOP;
                    end
                end
            end
            ucgf_pkg::ST_PARITY: begin
                if (samp) begin
                    rx_st_next = ucgf_pkg::ST_STOP;
                end
            end
            ucgf_pkg::ST_STOP: begin
                if (samp) begin
                    rx_st_next = ucgf_pkg::ST_IDLE;
                end
            end
            default: rx_st_next = ucgf_pkg::ST_IDLE;
        endcase
    end

    always_comb begin
        held_next = held_reg;
        held_w_next = held_w_reg;
        ovp_next = ovp_reg;
        push = 1'b0;
        wp_next = wp_reg;
        rp_next = rp_reg ^ pop;
        if (held_reg && room != ucgf_pkg::QUEUE_DEPTH) begin
            push = 1'b1;
            held_next = 1'b0;
        end else if (held_reg && start_det) begin
            held_next = 1'b0;
            ovp_next = 1'b1;
        end else if (done && room != ucgf_pkg::QUEUE_DEPTH) begin
            push = 1'b1;
            ovp_next = 1'b0;
        end else if (done) begin
            held_next = 1'b1;
            held_w_next = word;
            ovp_next = 1'b0;
        end
        if (push) begin
            wp_next = !wp_reg;
        end
        q_cnt_next = room + {1'b0, push};
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_entry
            assign mem_next[i] = (push && wp_reg == 1'(i))
                                 ? (held_reg ? held_w_reg : word) : mem_reg[i];
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_st_reg <= ucgf_pkg::ST_IDLE;
            rcnt_reg <= 4'h0;
            rbit_reg <= 4'h0;
            rsh_reg <= 9'h000;
            held_reg <= 1'b0;
            held_w_reg <= 11'h000;
            ovp_reg <= 1'b0;
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            q_cnt_reg <= 2'h0;
            mem_reg[0] <= 11'h000;
            mem_reg[1] <= 11'h000;
        end else begin
            rx_st_reg <= rx_st_next;
            rcnt_reg <= rcnt_next;
            rbit_reg <= rbit_next;
            rsh_reg <= rsh_next;
            held_reg <= held_next;
            held_w_reg <= held_w_next;
            ovp_reg <= ovp_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            q_cnt_reg <= q_cnt_next;
            mem_reg[0] <= mem_next[0];
            mem_reg[1] <= mem_next[1];
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence slave_rise_seq;
        slave && $rose(xck_i) ##2 slave;
    endsequence

    a_pop_once: assert property (@(posedge clk_i) disable iff (rst_i)
        (pop && q_cnt_reg == 2'h1 && !push) |=> (q_cnt_reg == 2'h0))
        else $error("queue read did not advance");

    a_status_travel: assert property (@(posedge clk_i) disable iff (rst_i)
        (done && !held_reg && q_cnt_reg == 2'h0) |=> (head[9] == $past(!rxd_i)))
        else $error("frame error not stored with character");

    a_third_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (done && !held_reg && q_cnt_reg == 2'h2 && !pop) |=> held_reg)
        else $error("full queue lost the finished character");

    a_master_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        master |-> !xck_oe_n_o)
        else $error("master does not drive the clock pin");

    a_async_release: assert property (@(posedge clk_i) disable iff (rst_i)
        (!sync_mode && !$past(master)) |-> (xck_oe_n_o && !xck_o))
        else $error("clock pin used in asynchronous mode");

    a_slave_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        slave_rise_seq |-> rise)
        else $error("slave clock edge not seen two clocks later");

    a_start_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_st_reg == ucgf_pkg::ST_START) |-> !txd_o)
        else $error("start bit not low");

    a_stop_high: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_st_reg == ucgf_pkg::ST_STOP || tx_st_reg == ucgf_pkg::ST_IDLE) |-> txd_o)
        else $error("stop or idle not high");

    a_edge_opposite: assert property (@(posedge clk_i) disable iff (rst_i)
        !(change_edge && sample_edge))
        else $error("change and sample on the same edge");

endmodule : ucgf_top

// ---- ucgf_peer.sv ----
// Remote serial peer that sends asynchronous frames of eight data bits on the receive line.
`timescale 1ns/1ps
module ucgf_peer (
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic [7:0] data_i,
    output logic rxd_o
);
    // Ones are shifted in behind the frame, so the line idles high between frames.
    logic [9:0] sh_reg = 10'h3FF;
    int cnt = 0;
    always @(posedge clk_i) begin
        if (send_i) begin
            sh_reg <= {1'b1, data_i, 1'b0};
            cnt <= 0;
        end else if (cnt == 15) begin
            sh_reg <= {1'b1, sh_reg[9:1]};
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    assign rxd_o = sh_reg[0];
endmodule : ucgf_peer

// ---- ucgf_top_bench.sv ----
// Self-checking bench for the serial clock and framing block.
`timescale 1ns/1ps
module ucgf_top_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, send = 1'b0;
    logic [7:0] adr = 8'h00, sdat = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic ack, txd, rxd, xck_o, xck_oe_n;
    logic transfer_clock_pin = 1'b0;
    int num_errors = 0, checked = 0;
    ucgf_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rxd_i(rxd), .txd_o(txd), .xck_i(transfer_clock_pin), .xck_o(xck_o), .xck_oe_n_o(xck_oe_n));
    ucgf_peer peer (.clk_i(clk_i), .send_i(send), .data_i(sdat), .rxd_o(rxd));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // The request is held until ack is seen or 50 clocks pass; a slower answer is cut short and counted as an error.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            num_errors++;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic test_reset();
        chk(32'(xck_oe_n), 32'h1);
        chk(32'(txd), 32'h1);
        wb(1'b0, ucgf_pkg::ADR_CSC, 32'h0);
        chk(q, 32'h0C0);
        wb(1'b0, ucgf_pkg::ADR_CSA, 32'h0);
        chk(q, 32'h20);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_rx();
        for (int i = 0; i < 2; i++) begin
            sdat <= i ? 8'hC3 : 8'h3C;
            send <= 1'b1;
            @(posedge clk_i);
            send <= 1'b0;
            repeat (170) @(posedge clk_i);
        end
        wb(1'b0, ucgf_pkg::ADR_CSA, 32'h0);
        chk(q & 32'h1F, 32'h10);
        wb(1'b0, ucgf_pkg::ADR_DATA, 32'h0);
        chk(q, 32'h3C);
        wb(1'b0, ucgf_pkg::ADR_DATA, 32'h0);
        chk(q, 32'hC3);
        wb(1'b0, ucgf_pkg::ADR_CSA, 32'h0);
        chk(q & 32'h10, 32'h0);
        $display("test_rx done");
    endtask : test_rx
    // Bit time bl is sixteen baud ticks of divisor plus one clocks each.
    task automatic test_tx(input int bl);
        logic [9:0] fr;
        int n;
        fr = {1'b1, 8'hA5, 1'b0};
        n = 0;
        wb(1'b1, ucgf_pkg::ADR_DATA, 32'hA5);
        while (txd !== 1'b0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        if (txd !== 1'b0) begin
            num_errors++;
        end
        repeat (bl / 2) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            chk(32'(txd), 32'(fr[i]));
            repeat (bl) @(posedge clk_i);
        end
        chk(32'(txd), 32'h1);
        $display("test_tx done");
    endtask : test_tx
    // Master clock with divisor one toggles on every second system clock.
    task automatic test_sync();
        logic x;
        wb(1'b1, ucgf_pkg::ADR_CSA, 32'h0);
        wb(1'b1, ucgf_pkg::ADR_CSC, 32'h0C5);
        chk(32'(xck_oe_n), 32'h0);
        x = xck_o;
        repeat (2) @(posedge clk_i);
        chk(32'(xck_o), 32'(!x));
        $display("test_sync done");
    endtask : test_sync
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        test_rx();
        test_tx(16);
        wb(1'b1, ucgf_pkg::ADR_DIVL, 32'h01);
        test_tx(32);
        test_sync();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        finish_test();
    end
endmodule : ucgf_top_bench
